// File: verilog/ref_cfg_pkg.sv
// Register map, field positions and reset values of the second reference,
// oscillator divider and switchover configuration slice.
// Assumes an 8-bit register port with 8-bit addresses, one clock, sync reset.
package ref_cfg_pkg;

   // Register addresses
   localparam logic [7:0] ADDR_SEC_DIV_HI   = 8'h23;
   localparam logic [7:0] ADDR_SEC_DIV_LO   = 8'h24;
   localparam logic [7:0] ADDR_SEC_CTRL     = 8'h25;
   localparam logic [7:0] ADDR_RSVD_26      = 8'h26;
   localparam logic [7:0] ADDR_OSC_DIV_HI   = 8'h27;
   localparam logic [7:0] ADDR_OSC_DIV_LO   = 8'h28;
   localparam logic [7:0] ADDR_SWITCH_CTRL  = 8'h29;
   localparam logic [7:0] ADDR_LAST_SLICE   = 8'h31;

   // Field positions
   localparam int BIT_DIV_SPI_SRC   = 1;
   localparam int BIT_DBL_SPI_SRC   = 7;
   localparam int BIT_DBL_SELECT    = 6;
   localparam int BIT_PRE_SPI_SRC   = 5;
   localparam int BIT_PRE_SELECT    = 4;
   localparam int BIT_DIFF_ENABLE   = 5;
   localparam int POS_SWITCH_MODE   = 6;

   // Masks of implemented bits; everything else reads zero
   localparam logic [7:0] MASK_DIV_LO = 8'hFE;
   localparam logic [7:0] MASK_CTRL   = 8'hF0;
   localparam logic [7:0] MASK_SWITCH = 8'hE0;

   // Reset values: divider fields 8192 and 4096, all control bits zero
   localparam logic [13:0] RST_SEC_DIV  = 14'h2000;
   localparam logic [13:0] RST_OSC_DIV  = 14'h1000;
   localparam logic [7:0]  RST_ZERO     = 8'h00;

   // Switchover modes
   typedef enum logic [1:0]
   {
      SW_REVERTIVE    = 2'h0,
      SW_NONREVERTIVE = 2'h1,
      SW_FORCE_FIRST  = 2'h2,
      SW_FORCE_SECOND = 2'h3
   } switch_mode_t;

endpackage : ref_cfg_pkg

// File: verilog/ratio_source_mux.sv
// Chooses between a strap-derived and a register-derived setting.
// Assumes both inputs are on clk; the output is registered.
`timescale 1ns/1ps
module ratio_source_mux #(
   parameter int WIDTH = 14
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             srst,
   // Sources
   input  wire logic             use_register,
   input  wire logic [WIDTH-1:0] strap_value,
   input  wire logic [WIDTH-1:0] register_value,
   input  wire logic [WIDTH-1:0] reset_value,
   // Chosen setting
   output logic      [WIDTH-1:0] chosen
);

   // Register field only counts while its enable bit is set
   wire [WIDTH-1:0] chosen_next = use_register ? register_value : strap_value;

   // Registered so top outputs come straight from a flip-flop
   always_ff @(posedge clk)
   begin
      if (srst)
         chosen <= reset_value;
      else
         chosen <= chosen_next;
   end

endmodule : ratio_source_mux

// File: verilog/ref_divider_switchover_cfg.sv
// Configuration slice at second_ref_divider_high..0x31: second reference divider, doubler and
// prescaler, oscillator divider, switchover mode and differential pairing.
// Assumes a serial-port decoder elsewhere hands over byte writes and reads
// on clk, and a strap lookup delivers its ratios already on clk.
`timescale 1ns/1ps

// Summary of operation
// - Second reference divider is 14 bits: second_ref_divider_high holds 13:6, second_ref_divider_low_and_source[7:2] holds 5:0.
// - Second reference divider field resets to 8192, used only when second_ref_divider_low_and_source[1] set.
// - second_ref_divider_low_and_source[1] picks strap lookup (0) or register value (1) for that divider.
// - second_ref_doubler_prescaler_control[7] picks strap lookup (0) or bit 6 (1) for doubler choice.
// - second_ref_doubler_prescaler_control[6] bypasses (0) or inserts (1) the doubler, only while bit 7 set.
// - second_ref_doubler_prescaler_control[5] picks strap lookup (0) or bit 4 (1) for divide-by-5 prescaler.
// - second_ref_doubler_prescaler_control[4] bypasses (0) or inserts (1) the prescaler, only while bit 5 set.
// - Oscillator divider is 14 bits: oscillator_divider_high holds 13:6, oscillator_divider_low_and_source[7:2] holds 5:0.
// - Oscillator divider field resets to 4096, used only when oscillator_divider_low_and_source[1] set.
// - oscillator_divider_low_and_source[1] picks strap lookup (0) or register value (1) for oscillator ratio.
// - switchover_and_differential_control[7:6] switchover: revertive, nonrevertive, force first, force second.
// - switchover_and_differential_control[5] pairs reference pins as one differential input, second channel off.
module ref_divider_switchover_cfg (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // Register port from the serial decoder
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_hit,
   // Strap lookup results
   input  wire logic [13:0] strap_second_ratio,
   input  wire logic        strap_second_doubler,
   input  wire logic        strap_second_prescaler,
   input  wire logic [13:0] strap_oscillator_ratio,
   // Effective settings to the synthesis path
   output logic [13:0]      second_divide_ratio,
   output logic             second_doubler_insert,
   output logic             second_prescaler_insert,
   output logic [13:0]      oscillator_divide_ratio,
   output logic [1:0]       switchover_mode,
   output logic             differential_reference_enable,
   output logic             second_channel_enable
);

   // Stored fields
   logic [13:0] sec_div_reg;
   logic        sec_src_reg;
   logic [3:0]  sec_ctrl_reg;
   logic [13:0] osc_div_reg;
   logic        osc_src_reg;
   logic [1:0]  sw_mode_reg;
   logic        diff_reg;

   // Address decode
   wire wr_hi_b  = reg_wr && (reg_addr == ref_cfg_pkg::ADDR_SEC_DIV_HI);
   wire wr_lo_b  = reg_wr && (reg_addr == ref_cfg_pkg::ADDR_SEC_DIV_LO);
   wire wr_ctl_b = reg_wr && (reg_addr == ref_cfg_pkg::ADDR_SEC_CTRL);
   wire wr_hi_x  = reg_wr && (reg_addr == ref_cfg_pkg::ADDR_OSC_DIV_HI);
   wire wr_lo_x  = reg_wr && (reg_addr == ref_cfg_pkg::ADDR_OSC_DIV_LO);
   wire wr_sw    = reg_wr && (reg_addr == ref_cfg_pkg::ADDR_SWITCH_CTRL);

   // Read image; unused bits and reserved_after_second_ref, 0x2A..0x31 read zero
   logic [7:0] rdata_next;
   always_comb
   begin
      case (reg_addr)
         ref_cfg_pkg::ADDR_SEC_DIV_HI:  rdata_next = sec_div_reg[13:6];
         ref_cfg_pkg::ADDR_SEC_DIV_LO:  rdata_next = {sec_div_reg[5:0], sec_src_reg, 1'b0};
         ref_cfg_pkg::ADDR_SEC_CTRL:    rdata_next = {sec_ctrl_reg, 4'h0};
         ref_cfg_pkg::ADDR_OSC_DIV_HI:  rdata_next = osc_div_reg[13:6];
         ref_cfg_pkg::ADDR_OSC_DIV_LO:  rdata_next = {osc_div_reg[5:0], osc_src_reg, 1'b0};
         ref_cfg_pkg::ADDR_SWITCH_CTRL: rdata_next = {sw_mode_reg, diff_reg, 5'h00};
         default:                       rdata_next = ref_cfg_pkg::RST_ZERO;
      endcase
   end

   // Whole slice second_ref_divider_high..0x31 answers, reserved addresses included
   wire hit_next = reg_rd && (reg_addr >= ref_cfg_pkg::ADDR_SEC_DIV_HI) &&
                   (reg_addr <= ref_cfg_pkg::ADDR_LAST_SLICE);

   // Read answer one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         reg_rdata <= ref_cfg_pkg::RST_ZERO;
         reg_hit   <= 1'b0;
      end
      else
      begin
         reg_rdata <= reg_rd ? rdata_next : ref_cfg_pkg::RST_ZERO;
         reg_hit   <= hit_next;
      end
   end

   // Second reference fields; masked so unused bits never store
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         sec_div_reg  <= ref_cfg_pkg::RST_SEC_DIV;
         sec_src_reg  <= 1'b0;
         sec_ctrl_reg <= 4'h0;
      end
      else
      begin
         if (wr_hi_b)
            sec_div_reg[13:6] <= reg_wdata;
         if (wr_lo_b)
         begin
            sec_div_reg[5:0] <= reg_wdata[7:2];
            sec_src_reg      <= reg_wdata[ref_cfg_pkg::BIT_DIV_SPI_SRC];
         end
         if (wr_ctl_b)
            sec_ctrl_reg <= reg_wdata[ref_cfg_pkg::BIT_PRE_SELECT +: 4];
      end
   end

   // Oscillator divider and switchover fields
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         osc_div_reg <= ref_cfg_pkg::RST_OSC_DIV;
         osc_src_reg <= 1'b0;
         sw_mode_reg <= ref_cfg_pkg::SW_REVERTIVE;
         diff_reg    <= 1'b0;
      end
      else
      begin
         if (wr_hi_x)
            osc_div_reg[13:6] <= reg_wdata;
         if (wr_lo_x)
         begin
            osc_div_reg[5:0] <= reg_wdata[7:2];
            osc_src_reg      <= reg_wdata[ref_cfg_pkg::BIT_DIV_SPI_SRC];
         end
         if (wr_sw)
         begin
            sw_mode_reg <= reg_wdata[ref_cfg_pkg::POS_SWITCH_MODE +: 2];
            diff_reg    <= reg_wdata[ref_cfg_pkg::BIT_DIFF_ENABLE];
         end
      end
   end

   // Control bits decoded from the stored nibble of second_ref_doubler_prescaler_control
   wire dbl_spi = sec_ctrl_reg[ref_cfg_pkg::BIT_DBL_SPI_SRC - 4];
   wire dbl_sel = sec_ctrl_reg[ref_cfg_pkg::BIT_DBL_SELECT - 4];
   wire pre_spi = sec_ctrl_reg[ref_cfg_pkg::BIT_PRE_SPI_SRC - 4];
   wire pre_sel = sec_ctrl_reg[ref_cfg_pkg::BIT_PRE_SELECT - 4];

   // Divider sources; one mux each so both paths behave alike
   ratio_source_mux #(.WIDTH(14)) u_second_ratio (
      .clk            (clk),
      .srst           (srst),
      .use_register   (sec_src_reg),
      .strap_value    (strap_second_ratio),
      .register_value (sec_div_reg),
      .reset_value    (ref_cfg_pkg::RST_SEC_DIV),
      .chosen         (second_divide_ratio)
   );

   ratio_source_mux #(.WIDTH(14)) u_osc_ratio (
      .clk            (clk),
      .srst           (srst),
      .use_register   (osc_src_reg),
      .strap_value    (strap_oscillator_ratio),
      .register_value (osc_div_reg),
      .reset_value    (ref_cfg_pkg::RST_OSC_DIV),
      .chosen         (oscillator_divide_ratio)
   );

   ratio_source_mux #(.WIDTH(1)) u_doubler (
      .clk            (clk),
      .srst           (srst),
      .use_register   (dbl_spi),
      .strap_value    (strap_second_doubler),
      .register_value (dbl_sel),
      .reset_value    (1'b0),
      .chosen         (second_doubler_insert)
   );

   ratio_source_mux #(.WIDTH(1)) u_prescaler (
      .clk            (clk),
      .srst           (srst),
      .use_register   (pre_spi),
      .strap_value    (strap_second_prescaler),
      .register_value (pre_sel),
      .reset_value    (1'b0),
      .chosen         (second_prescaler_insert)
   );

   // Differential pairing overrides switchover: the second channel is gone,
   // so switchover is pinned to the first reference
   wire [1:0] mode_next = diff_reg ? ref_cfg_pkg::SW_FORCE_FIRST : sw_mode_reg;

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         switchover_mode               <= ref_cfg_pkg::SW_REVERTIVE;
         differential_reference_enable <= 1'b0;
         second_channel_enable         <= 1'b1;
      end
      else
      begin
         switchover_mode               <= mode_next;
         differential_reference_enable <= diff_reg;
         second_channel_enable         <= ~diff_reg;
      end
   end

   // Checks on the effective settings
   a_second_div_src: assert property (@(posedge clk) disable iff (srst)
      ##1 !$past(srst) |-> second_divide_ratio ==
         ($past(sec_src_reg) ? $past(sec_div_reg) : $past(strap_second_ratio)))
      else $error("second divider source wrong");
   a_osc_div_src: assert property (@(posedge clk) disable iff (srst)
      ##1 !$past(srst) |-> oscillator_divide_ratio ==
         ($past(osc_src_reg) ? $past(osc_div_reg) : $past(strap_oscillator_ratio)))
      else $error("oscillator divider source wrong");
   a_doubler_gate: assert property (@(posedge clk) disable iff (srst)
      !dbl_spi ##1 !$past(srst) |-> second_doubler_insert == $past(strap_second_doubler))
      else $error("doubler select used while disabled");
   a_prescale_gate: assert property (@(posedge clk) disable iff (srst)
      pre_spi && pre_sel ##1 1'b1 |-> second_prescaler_insert)
      else $error("prescaler select not applied");
   a_div_write_lo: assert property (@(posedge clk) disable iff (srst)
      wr_lo_b |=> sec_div_reg[5:0] == $past(reg_wdata[7:2]))
      else $error("second divider low bits not stored");
   a_osc_write_hi: assert property (@(posedge clk) disable iff (srst)
      wr_hi_x |=> osc_div_reg[13:6] == $past(reg_wdata))
      else $error("oscillator divider high bits not stored");
   a_diff_mode: assert property (@(posedge clk) disable iff (srst)
      diff_reg ##1 1'b1 |-> !second_channel_enable &&
         switchover_mode == ref_cfg_pkg::SW_FORCE_FIRST)
      else $error("differential mode leaves second channel on");
   a_switch_mode: assert property (@(posedge clk) disable iff (srst)
      wr_sw && !reg_wdata[5] ##1 !wr_sw ##1 1'b1 |-> switchover_mode == $past(reg_wdata[7:6], 2))
      else $error("switchover mode not applied");
   a_unused_zero: assert property (@(posedge clk) disable iff (srst)
      reg_rd && reg_addr == ref_cfg_pkg::ADDR_RSVD_26 |=> reg_rdata == 8'h00 && reg_hit)
      else $error("reserved register not read as zero");

endmodule : ref_divider_switchover_cfg

// File: verification/reg_host_model.sv
// Partner model: serial decoder side issuing byte writes and reads.
// Assumes the slice's strobe port on the same clk, driven at falling edges.
`timescale 1ns/1ps
module reg_host_model (
   // Clock
   input  wire logic       clk,
   // Register port
   output logic            reg_wr,
   output logic            reg_rd,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_hit
);
   // Idle from time zero
   initial
   begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // Idle bus shows inverted stale values so nothing leans on old data
   task automatic idle();
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask : idle

   // One byte write, held across the taking edge
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      idle();
   endtask : write

   // One read; data and hit stand for the cycle after the taking edge
   task automatic read(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(negedge clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk);
      d = reg_rdata;
      h = reg_hit;
      idle();
   endtask : read
endmodule : reg_host_model

// File: verification/tb_top.sv
// Self-checking bench for the reference divider and switchover slice.
// Assumes the host model as partner and strap results driven by the bench.
`timescale 1ns/1ps
module tb_top;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        reg_wr, reg_rd, reg_hit, hv;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv;
   logic [13:0] strap_second_ratio = 14'h0000;
   logic [13:0] strap_oscillator_ratio = 14'h0000;
   logic        strap_second_doubler = 1'b0;
   logic        strap_second_prescaler = 1'b0;
   logic [13:0] second_divide_ratio, oscillator_divide_ratio;
   logic        second_doubler_insert, second_prescaler_insert;
   logic [1:0]  switchover_mode;
   logic        differential_reference_enable, second_channel_enable;
   int          fail_count = 0;
   int          samples_checked = 0;
   int          cycles = 0;

   ref_divider_switchover_cfg i_ref_divider_switchover_cfg (.clk, .srst, .reg_wr,
      .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .strap_second_ratio,
      .strap_second_doubler, .strap_second_prescaler, .strap_oscillator_ratio,
      .second_divide_ratio, .second_doubler_insert, .second_prescaler_insert,
      .oscillator_divide_ratio, .switchover_mode, .differential_reference_enable,
      .second_channel_enable);
   reg_host_model i_reg_host_model (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
      .reg_rdata, .reg_hit);

   always #10 clk = ~clk;

   task automatic test_done();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   // Hang guard: the tests need under two hundred cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         fail_count++;
         test_done();
      end
   end

   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Write, then let the effective outputs take the stored field
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_host_model.write(a, d);
      @(negedge clk);
   endtask : wr

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic h);
      i_reg_host_model.read(a, rv, hv);
      chk("rdata", {8'h00, e}, {8'h00, rv});
      chk("hit", {15'h0, h}, {15'h0, hv});
   endtask : rchk

   task automatic t_reset();
      rchk(8'h23, 8'h80, 1'b1);
      rchk(8'h24, 8'h00, 1'b1);
      rchk(8'h25, 8'h00, 1'b1);
      rchk(8'h27, 8'h40, 1'b1);
      rchk(8'h28, 8'h00, 1'b1);
      rchk(8'h29, 8'h00, 1'b1);
      chk("chan", 16'h1, {15'h0, second_channel_enable});
   endtask : t_reset

   task automatic t_div();
      strap_second_ratio = 14'h1234;
      strap_oscillator_ratio = 14'h0ABC;
      @(negedge clk);
      chk("ratio", 16'h1234, {2'b0, second_divide_ratio});
      chk("osc", 16'h0ABC, {2'b0, oscillator_divide_ratio});
      wr(8'h23, 8'h5A);
      chk("ratio", 16'h1234, {2'b0, second_divide_ratio});
      wr(8'h24, 8'hAE);
      chk("ratio", 16'h16AB, {2'b0, second_divide_ratio});
      wr(8'h27, 8'hC3);
      chk("osc", 16'h0ABC, {2'b0, oscillator_divide_ratio});
      wr(8'h28, 8'h56);
      chk("osc", 16'h30D5, {2'b0, oscillator_divide_ratio});
      strap_second_ratio = 14'h0001;
      wr(8'h28, 8'h54);
      chk("ratio", 16'h16AB, {2'b0, second_divide_ratio});
      chk("osc", 16'h0ABC, {2'b0, oscillator_divide_ratio});
      rchk(8'h24, 8'hAE, 1'b1);
   endtask : t_div

   // Every combination of the four control bits against opposing straps
   task automatic t_ctrl();
      for (int i = 0; i < 16; i++)
      begin
         logic [3:0] v;
         v = i[3:0];
         strap_second_doubler = ~v[2];
         strap_second_prescaler = ~v[0];
         wr(8'h25, {v, 4'h0});
         chk("dbl", {15'h0, v[3] ? v[2] : ~v[2]}, {15'h0, second_doubler_insert});
         chk("pre", {15'h0, v[1] ? v[0] : ~v[0]}, {15'h0, second_prescaler_insert});
      end
      rchk(8'h25, 8'hF0, 1'b1);
   endtask : t_ctrl

   task automatic t_switch();
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h29, {m[1:0], 6'h00});
         chk("mode", m[15:0], {14'h0, switchover_mode});
         rchk(8'h29, {m[1:0], 6'h00}, 1'b1);
      end
      wr(8'h29, 8'hE0);
      chk("mode", 16'h2, {14'h0, switchover_mode});
      chk("diff", 16'h1, {15'h0, differential_reference_enable});
      chk("chan", 16'h0, {15'h0, second_channel_enable});
      rchk(8'h29, 8'hE0, 1'b1);
   endtask : t_switch

   // Unused bits and places ignore writes and read zero
   task automatic t_unused();
      wr(8'h26, 8'hFF);
      wr(8'h2A, 8'hFF);
      wr(8'h31, 8'hFF);
      wr(8'h24, 8'hFF);
      wr(8'h29, 8'h1F);
      wr(8'h25, 8'h0F);
      rchk(8'h25, 8'h00, 1'b1);
      rchk(8'h26, 8'h00, 1'b1);
      rchk(8'h2A, 8'h00, 1'b1);
      rchk(8'h31, 8'h00, 1'b1);
      rchk(8'h24, 8'hFE, 1'b1);
      rchk(8'h29, 8'h00, 1'b1);
      rchk(8'h22, 8'h00, 1'b0);
      rchk(8'h32, 8'h00, 1'b0);
   endtask : t_unused

   // Mid-run reset brings every field back to default, so straps rule again
   task automatic t_rerun();
      srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      rchk(8'h23, 8'h80, 1'b1);
      rchk(8'h24, 8'h00, 1'b1);
      rchk(8'h27, 8'h40, 1'b1);
      chk("ratio", 16'h0001, {2'b0, second_divide_ratio});
      chk("osc", 16'h0ABC, {2'b0, oscillator_divide_ratio});
   endtask : t_rerun

   initial
   begin
      repeat (12) @(negedge clk);
      srst = 1'b0;
      t_reset();
      t_div();
      t_ctrl();
      t_switch();
      t_unused();
      t_rerun();
      test_done();
   end
endmodule : tb_top
